/* File: src/cfg_loader_regs.svh */
// Constants for the serial configuration word loader and its register map.
`ifndef CFG_LOADER_REGS_SVH
`define CFG_LOADER_REGS_SVH

`define CFG_WORD_BITS      18
`define CFG_COUNT_BITS     5
`define CFG_MAX_SHIFT      5'h12
`define CFG_DEFAULT_WORD   18'h10F04

`define CFG_BIT_CRC_LEN    17
`define CFG_BIT_CRC_EN     16
`define CFG_BIT_MODE       14
`define CFG_BIT_RATE       13
`define CFG_XO_MSB         12
`define CFG_XO_LSB         10
`define CFG_PWR_MSB        9
`define CFG_PWR_LSB        8
`define CFG_CH_MSB         7
`define CFG_CH_LSB         1

`define CFG_BASE_FREQ_MHZ  12'h960

`define REG_OFS_WORD       4'h0
`define REG_OFS_STATUS     4'h4
`define REG_OFS_CTRL       4'h8

`define STAT_OVERRUN_BIT   9
`define STAT_SELECT_BIT    8
`define CTRL_ENABLE_BIT    0
`define CTRL_RESTORE_BIT   1
`define CTRL_RESET_VALUE   1'b1

`endif

/* File: src/cfg_loader_pkg.sv */
// Types shared by the configuration word loader modules.
`include "cfg_loader_regs.svh"

package cfg_loader_pkg;

    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b01,
        LINK_SHIFT = 2'b10
    } link_state_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } sync_state_t;

    typedef struct packed {
        link_state_t                  state;
        logic [`CFG_WORD_BITS-1:0]    shift;
        logic [`CFG_COUNT_BITS-1:0]   count;
        logic [`CFG_WORD_BITS-1:0]    cfg;
        logic [`CFG_COUNT_BITS-1:0]   last_count;
        logic                         overrun;
        logic                         link_en;
        logic                         ack;
        logic [31:0]                  rdata;
        logic                         crc_en;
        logic                         crc_len_16;
        logic                         comm_mode_sel;
        logic                         air_rate_sel;
        logic [2:0]                   crystal_freq_code;
        logic [1:0]                   output_power_code;
        logic [6:0]                   channel_number;
        logic [4:0]                   crystal_mhz;
        logic [5:0]                   power_dbm;
        logic [11:0]                  tx_freq_mhz;
        logic                         rate_conflict;
    } loader_state_t;

endpackage

/* File: src/link_pin_sync.sv */
// Two-stage synchroniser with edge detection for the three link pins.
`timescale 1ns/1ps

module link_pin_sync (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic [2:0] pins,
    output logic      [2:0] level,
    output logic      [2:0] rise,
    output logic      [2:0] fall
);
    import cfg_loader_pkg::*;

    cfg_loader_pkg::sync_state_t st_ff;
    cfg_loader_pkg::sync_state_t nxt_st;

    // Stage one feeds only stage two; the edge logic looks at stages two and three.
    always_comb begin
        nxt_st = st_ff;
        if (ce) begin
            nxt_st.s1 = pins;
            nxt_st.s2 = st_ff.s1;
            nxt_st.s3 = st_ff.s2;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Data and clock pass the same number of stages, so they stay aligned.
    assign level = st_ff.s2;
    assign rise  = st_ff.s2 & ~st_ff.s3;
    assign fall  = ~st_ff.s2 & st_ff.s3;

endmodule

/* File: src/cfg_word_loader.sv */
// Serial configuration word loader with field decode and Avalon-MM access.
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "cfg_loader_regs.svh"

module cfg_word_loader (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Three-wire configuration link from the controller.
    input  wire logic        config_select,
    input  wire logic        config_shift_clock,
    input  wire logic        config_data,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Decoded configuration.
    output logic [17:0]      cfg_word,
    output logic             crc_en,
    output logic             crc_len_16,
    output logic             comm_mode_sel,
    output logic             air_rate_sel,
    output logic [2:0]       crystal_freq_code,
    output logic [1:0]       output_power_code,
    output logic [6:0]       channel_number,
    output logic [4:0]       crystal_mhz,
    output logic [5:0]       power_dbm,
    output logic [11:0]      tx_freq_mhz,
    output logic             rate_conflict
);
    import cfg_loader_pkg::*;

    localparam int SEL = 0;
    localparam int SCK = 1;
    localparam int DAT = 2;

    cfg_loader_pkg::loader_state_t st_ff;
    cfg_loader_pkg::loader_state_t nxt_st;

    logic [2:0]  pin_level;
    logic [2:0]  pin_rise;
    logic [2:0]  pin_fall;
    logic        bus_req;
    logic [17:0] load_mask;
    logic [17:0] src_word;

    // The link pins come from another clock domain and are synchronised first.
    link_pin_sync u_sync (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .pins  ({config_data, config_shift_clock, config_select}),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    assign bus_req = avs_read | avs_write;

    // Mask of the low positions written by the last load; 18 bits gives all ones.
    assign load_mask = 18'((19'h00001 << st_ff.count) - 19'h00001);

    // Decode source is the registered word so outputs change one cycle after it.
    assign src_word = st_ff.cfg;

    // Single process for link, bus and decode; ce low freezes every field.
    always_comb begin
        nxt_st = st_ff;
        if (ce) begin
            // Bus handshake: one wait cycle, then the answer edge.
            nxt_st.ack = bus_req & ~st_ff.ack;
            if (avs_read && !st_ff.ack) begin
                if (avs_address == `REG_OFS_WORD) begin
                    nxt_st.rdata = {14'h0000, st_ff.cfg};
                end else if (avs_address == `REG_OFS_STATUS) begin
                    nxt_st.rdata = {22'h000000, st_ff.overrun,
                                    st_ff.state == LINK_SHIFT,
                                    3'h0, st_ff.last_count};
                end else if (avs_address == `REG_OFS_CTRL) begin
                    nxt_st.rdata = {31'h00000000, st_ff.link_en};
                end else begin
                    nxt_st.rdata = 32'h00000000;
                end
            end
            // Writes land on the edge where waitrequest is low.
            if (avs_write && st_ff.ack) begin
                if (avs_address == `REG_OFS_STATUS) begin
                    if (avs_byteenable[1] && avs_writedata[`STAT_OVERRUN_BIT]) begin
                        nxt_st.overrun = 1'b0;
                    end
                end else if (avs_address == `REG_OFS_CTRL) begin
                    if (avs_byteenable[0]) begin
                        nxt_st.link_en = avs_writedata[`CTRL_ENABLE_BIT];
                        if (avs_writedata[`CTRL_RESTORE_BIT]) begin
                            // Software restore behaves like a reset of the word.
                            nxt_st.cfg   = `CFG_DEFAULT_WORD;
                            nxt_st.count = '0;
                            nxt_st.state = LINK_IDLE;
                        end
                    end
                end
            end

            // Link state machine; it runs after the bus so a set beats a clear.
            case (st_ff.state)
                LINK_IDLE: begin
                    // Shifting opens only on a high select while the link is enabled.
                    if (pin_level[SEL] && st_ff.link_en) begin
                        nxt_st.state = LINK_SHIFT;
                        nxt_st.count = '0;
                    end
                end
                LINK_SHIFT: begin
                    if (!pin_level[SEL]) begin
                        // Apply only on the falling select edge.
                        nxt_st.cfg = (st_ff.cfg & ~load_mask)
                                   | (st_ff.shift & load_mask);
                        nxt_st.last_count = st_ff.count;
                        nxt_st.state      = LINK_IDLE;
                    end else if (pin_rise[SCK]) begin
                        // MSB first: each new bit enters at bit 0.
                        nxt_st.shift = {st_ff.shift[16:0], pin_level[DAT]};
                        if (st_ff.count == `CFG_MAX_SHIFT) begin
                            // Extra bits keep only the latest eighteen.
                            nxt_st.overrun = 1'b1;
                        end else begin
                            nxt_st.count = st_ff.count + 5'h01;
                        end
                    end
                end
                default: begin
                    nxt_st.state = LINK_IDLE;
                end
            endcase

            // Field decode from the applied word.
            nxt_st.comm_mode_sel = src_word[`CFG_BIT_MODE];
            // Direct mode ignores the CRC bits.
            nxt_st.crc_en     = src_word[`CFG_BIT_CRC_EN] & src_word[`CFG_BIT_MODE];
            nxt_st.crc_len_16 = src_word[`CFG_BIT_CRC_LEN] & src_word[`CFG_BIT_MODE];
            nxt_st.air_rate_sel      = src_word[`CFG_BIT_RATE];
            nxt_st.crystal_freq_code = src_word[`CFG_XO_MSB:`CFG_XO_LSB];
            nxt_st.output_power_code = src_word[`CFG_PWR_MSB:`CFG_PWR_LSB];
            nxt_st.channel_number    = src_word[`CFG_CH_MSB:`CFG_CH_LSB];
            nxt_st.tx_freq_mhz = `CFG_BASE_FREQ_MHZ
                               + {5'h00, src_word[`CFG_CH_MSB:`CFG_CH_LSB]};

            // Crystal code to MHz; codes above 20 MHz decode as zero.
            case (src_word[`CFG_XO_MSB:`CFG_XO_LSB])
                3'h0:    nxt_st.crystal_mhz = 5'h04;
                3'h1:    nxt_st.crystal_mhz = 5'h08;
                3'h2:    nxt_st.crystal_mhz = 5'h0C;
                3'h3:    nxt_st.crystal_mhz = 5'h10;
                3'h4:    nxt_st.crystal_mhz = 5'h14;
                default: nxt_st.crystal_mhz = 5'h00;
            endcase

            // Power code to signed dBm in two's complement.
            case (src_word[`CFG_PWR_MSB:`CFG_PWR_LSB])
                2'h0:    nxt_st.power_dbm = 6'h2C;
                2'h1:    nxt_st.power_dbm = 6'h36;
                2'h2:    nxt_st.power_dbm = 6'h3B;
                default: nxt_st.power_dbm = 6'h00;
            endcase

            // Flags 1 Mbps without the 16 MHz crystal; the setting is not blocked.
            nxt_st.rate_conflict = src_word[`CFG_BIT_RATE]
                                 & (src_word[`CFG_XO_MSB:`CFG_XO_LSB] != 3'h3);
        end
    end

    // Reset restores the default word and discards any partial shift.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff                   <= '0;
            st_ff.state             <= LINK_IDLE;
            st_ff.cfg               <= `CFG_DEFAULT_WORD;
            st_ff.link_en           <= `CTRL_RESET_VALUE;
            st_ff.crc_en            <= 1'b0;
            st_ff.comm_mode_sel     <= 1'b0;
            st_ff.crystal_freq_code <= 3'h3;
            st_ff.output_power_code <= 2'h3;
            st_ff.channel_number    <= 7'h02;
            st_ff.crystal_mhz       <= 5'h10;
            st_ff.tx_freq_mhz       <= 12'h962;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Waitrequest is combinational; read data comes from a flop.
    assign avs_waitrequest   = bus_req & ~st_ff.ack;
    assign avs_readdata      = st_ff.rdata;
    assign cfg_word          = st_ff.cfg;
    assign crc_en            = st_ff.crc_en;
    assign crc_len_16        = st_ff.crc_len_16;
    assign comm_mode_sel     = st_ff.comm_mode_sel;
    assign air_rate_sel      = st_ff.air_rate_sel;
    assign crystal_freq_code = st_ff.crystal_freq_code;
    assign output_power_code = st_ff.output_power_code;
    assign channel_number    = st_ff.channel_number;
    assign crystal_mhz       = st_ff.crystal_mhz;
    assign power_dbm         = st_ff.power_dbm;
    assign tx_freq_mhz       = st_ff.tx_freq_mhz;
    assign rate_conflict     = st_ff.rate_conflict;

endmodule

/* File: tb/cfg_word_loader_props.sv */
// Concurrent checks on the loader's bus answer, applied word and decoded fields.
`timescale 1ns/1ps
module cfg_word_loader_props (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        config_select,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [17:0] cfg_word,
    input wire logic        crc_en,
    input wire logic        crc_len_16,
    input wire logic        comm_mode_sel,
    input wire logic        air_rate_sel,
    input wire logic [2:0]  crystal_freq_code,
    input wire logic [1:0]  output_power_code,
    input wire logic [6:0]  channel_number,
    input wire logic [4:0]  crystal_mhz,
    input wire logic [5:0]  power_dbm,
    input wire logic [11:0] tx_freq_mhz
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // A request is taken in one cycle and answered in the next.
    sequence req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answered;
        !avs_waitrequest;
    endsequence

    a_bus_one_wait: assert property (req_taken |=> answered)
        else $error("bus answer not one cycle after request");
    // Six select-high cycles leave no room for a pending apply, so the word must hold.
    a_word_held: assert property (config_select [*6] |-> $stable(cfg_word))
        else $error("word changed while select high");
    a_crc_enable: assert property (1'b1 |=>
        crc_en == ($past(cfg_word[16]) && $past(cfg_word[14])))
        else $error("crc enable decode wrong");
    a_crc_length: assert property (1'b1 |=>
        crc_len_16 == ($past(cfg_word[17]) && $past(cfg_word[14])))
        else $error("crc length decode wrong");
    a_mode_rate: assert property (1'b1 |=> comm_mode_sel == $past(cfg_word[14])
        && air_rate_sel == $past(cfg_word[13]))
        else $error("mode or rate decode wrong");
    a_xo_decode: assert property (1'b1 |=> crystal_freq_code == $past(cfg_word[12:10])
        && crystal_mhz == ((crystal_freq_code < 3'h5) ? {crystal_freq_code, 2'b00} + 5'h04
        : 5'h00))
        else $error("crystal decode wrong");
    a_power_decode: assert property (1'b1 |=> output_power_code == $past(cfg_word[9:8])
        && power_dbm == (output_power_code == 2'h0 ? 6'h2C : output_power_code == 2'h1
        ? 6'h36 : output_power_code == 2'h2 ? 6'h3B : 6'h00))
        else $error("power decode wrong");
    a_chan_freq: assert property (1'b1 |=> channel_number == $past(cfg_word[7:1])
        && tx_freq_mhz == 12'h960 + channel_number)
        else $error("channel or frequency wrong");
    a_direct_crc_off: assert property (!comm_mode_sel |-> !crc_en && !crc_len_16)
        else $error("crc active in direct mode");
    a_reset_default: assert property ($rose(rstn) |-> cfg_word == 18'h10F04)
        else $error("word not default after reset");
endmodule

bind cfg_word_loader cfg_word_loader_props u_props (
    .clk, .rstn, .config_select, .avs_read, .avs_write, .avs_waitrequest, .cfg_word,
    .crc_en, .crc_len_16, .comm_mode_sel, .air_rate_sel, .crystal_freq_code,
    .output_power_code, .channel_number, .crystal_mhz, .power_dbm, .tx_freq_mhz
);

/* File: tb/cfg_link_ctrl.sv */
// Behavioural controller that drives the three-wire configuration link.
`timescale 1ns/1ps
module cfg_link_ctrl (
    input  wire logic clk,
    output logic      config_select,
    output logic      config_shift_clock,
    output logic      config_data
);
    // The link clock stands low between frames.
    initial begin
        config_select      = 1'b0;
        config_shift_clock = 1'b0;
        config_data        = 1'b0;
    end

    // Sends the low n bits of v; with sel low the clock runs without select on purpose.
    task automatic shift(input logic [17:0] v, input int n, input logic sel);
        repeat (10) @(posedge clk);
        config_select <= sel;
        for (int i = n - 1; i >= 0; i--) begin
            repeat (10) @(posedge clk);
            config_shift_clock <= 1'b0;
            config_data        <= v[i];
            repeat (10) @(posedge clk);
            config_shift_clock <= 1'b1;
        end
        repeat (10) @(posedge clk);
        config_shift_clock <= 1'b0;
        repeat (10) @(posedge clk);
        config_select <= 1'b0;
        // A released data line shows the inverse so stale values cannot pass.
        config_data <= ~config_data;
        repeat (12) @(posedge clk);
    endtask
endmodule

/* File: tb/radio_tx_config_word_loader_tb_top.sv */
// Self-checking bench for the serial configuration word loader.
`timescale 1ns/1ps
module radio_tx_config_word_loader_tb_top;
    logic        clk;
    logic        rstn;
    logic        ce;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sel;
    logic        sck;
    logic        sdat;
    logic [17:0] cfg_word;
    logic        crc_en;
    logic        crc_len_16;
    logic        comm_mode_sel;
    logic        air_rate_sel;
    logic [2:0]  crystal_freq_code;
    logic [1:0]  output_power_code;
    logic [6:0]  channel_number;
    logic [4:0]  crystal_mhz;
    logic [5:0]  power_dbm;
    logic [11:0] tx_freq_mhz;
    logic        rate_conflict;
    logic [17:0] w;
    logic [31:0] rd;
    logic [5:0]  dbm_tab [4] = '{6'h2C, 6'h36, 6'h3B, 6'h00};
    int          err_total = 0;
    int          num_checks = 0;

    cfg_word_loader u_dut (
        .clk, .rstn, .ce, .config_select(sel), .config_shift_clock(sck),
        .config_data(sdat), .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .cfg_word, .crc_en, .crc_len_16,
        .comm_mode_sel, .air_rate_sel, .crystal_freq_code, .output_power_code,
        .channel_number, .crystal_mhz, .power_dbm, .tx_freq_mhz, .rate_conflict
    );
    cfg_link_ctrl u_link (
        .clk, .config_select(sel), .config_shift_clock(sck), .config_data(sdat)
    );

    // Free-running 125 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // The request stands until waitrequest is sampled low at a rising edge; data is taken there.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= wd;
        avs_byteenable <= 4'hF;
        avs_read       <= !wr;
        avs_write      <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Every decoded output is worked out here from the word that should be applied.
    task automatic chk_dec(input logic [17:0] e);
        logic [2:0] x;
        x = e[12:10];
        check("cfg_word", e, cfg_word);
        check("crc_en", e[16] & e[14], crc_en);
        check("crc_len_16", e[17] & e[14], crc_len_16);
        check("mode", e[14], comm_mode_sel);
        check("rate", e[13], air_rate_sel);
        check("codes", e[12:8], {crystal_freq_code, output_power_code});
        check("crystal_mhz", (x < 3'h5) ? {x, 2'b00} + 5'h04 : 5'h00, crystal_mhz);
        check("power_dbm", dbm_tab[e[9:8]], power_dbm);
        check("channel", e[7:1], channel_number);
        check("tx_freq", 12'h960 + e[7:1], tx_freq_mhz);
        check("conflict", e[13] & (x != 3'h3), rate_conflict);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The whole run needs some 4,300 cycles; this limit only catches a hang.
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk_dec(18'h10F04);
        bus(1'b0, 4'h0, 32'h0);
        check("word_reg", 32'h10F04, rd);
        bus(1'b0, 4'hC, 32'h0);
        check("unmapped", 32'h0, rd);
        $display("test defaults done");
        w = 18'h36EAA; // Reserved bits 15 and 0 are sent as zero.
        u_link.shift(w, 18, 1'b1);
        chk_dec(w);
        $display("test full word done");
        for (int i = 0; i < 5; i++) begin
            w[12:0] = {i[2:0], i[1:0], 7'(i * 9), 1'b0};
            u_link.shift(w, 13, 1'b1);
            chk_dec(w);
        end
        bus(1'b0, 4'h4, 32'h0);
        check("bit_count", 32'h0000000D, rd);
        $display("test short loads done");
        w[7:0] = 8'hFE; // Top channel stays within the band.
        u_link.shift(w, 8, 1'b1);
        chk_dec(w);
        w[15:0] = 16'h0F04;
        u_link.shift(w, 16, 1'b1);
        chk_dec(w);
        $display("test channel and direct done");
        u_link.shift(18'h00000, 18, 1'b0);
        chk_dec(w);
        bus(1'b1, 4'h8, 32'h0);
        u_link.shift(18'h00000, 8, 1'b1);
        chk_dec(w);
        bus(1'b1, 4'h8, 32'h1);
        $display("test ignored clocks done");
        bus(1'b1, 4'h8, 32'h3); // Enable stays set while the word is restored.
        repeat (4) @(posedge clk);
        chk_dec(18'h10F04);
        bus(1'b0, 4'h8, 32'h0);
        check("ctrl", 32'h1, rd);
        u_link.shift(w, 18, 1'b1);
        chk_dec(w);
        ce <= 1'b0;
        u_link.shift(18'h00000, 18, 1'b1); // A frozen clock enable loses every link edge.
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        chk_dec(w);
        $display("test restore and clock enable done");
        fork
            u_link.shift(18'h3FFFE, 18, 1'b1);
            begin
                repeat (100) @(posedge clk);
                rstn <= 1'b0;
            end
        join
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk_dec(18'h10F04);
        $display("test reset mid load done");
        tally_and_finish();
    end
endmodule
